// ==== bsm_pkg.sv ====
// Package with constants and types for the boot strap mode selector.
`default_nettype none
package bsm_pkg;

    localparam int STRAP_W = 3;

    // ------------------------------------------------------------------
    // Strap codes
    // ------------------------------------------------------------------
    localparam logic [2:0] RUN_FOUR_WIRE_CODE = 3'h0;
    localparam logic [2:0] RUN_TWO_WIRE_CODE = 3'h1;
    localparam logic [2:0] PROBE_LOAD_OR_RUN_CODE = 3'h2;
    localparam logic [2:0] RESTORE_DEFAULTS_CODE = 3'h3;
    localparam logic [2:0] LOAD_OVER_SERIAL_CODE = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RESTORE_TIME_S = 8;
    localparam longint RESTORE_CYC =
        longint'(RESTORE_TIME_S) * 1000000 * CLK_MHZ;
    localparam int BREAK_CYC = 1024;
    // The probe gives up after this many break windows without a break.
    localparam int PROBE_SPAN = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RST_NONE,
        RST_PARAMS,
        RST_IMAGE_PARAMS
    } bsm_restore_type;

    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_UART_LOAD,
        MODE_FUNC_TWO_WIRE,
        MODE_FUNC_FOUR_WIRE,
        MODE_UART_PROBE,
        MODE_FACTORY_RESTORE
    } bsm_mode_type;

    typedef struct packed {
        logic uart_load;
        logic functional;
        logic two_wire_dbg;
        logic four_wire_dbg;
    } bsm_boot_type;

endpackage
`default_nettype wire

// ==== bsm_break_det.sv ====
// UART break detector: receive line held low for a number of cycles.
`timescale 1ns/10ps
`default_nettype none
module bsm_break_det #(
    parameter int BREAK_CYCLES = 1024
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic enable_i,
    input wire logic uart_rx_i,
    // Result
    output logic break_o
);
    localparam int CW = $clog2(BREAK_CYCLES + 1);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
            break_o <= 1'b0;
        end else if (!enable_i || uart_rx_i) begin
            cnt_r <= '0;
            break_o <= 1'b0;
        end else if (cnt_r == CW'(BREAK_CYCLES)) begin
            break_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule
`default_nettype wire

// ==== bsm_boot_strap_mode_select.sv ====
// Top of the boot strap mode selector: latch, decode, restore sequencing.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Latch straps on the first clock after reset release.
// - Internal pulldowns; open straps mean four-wire functional.
// - Top strap alone: wait for serial load until the straps change.
// - Bottom strap alone: functional with two-wire debug.
// - All low: functional with four-wire debug.
// - Middle strap alone: serial break enters load mode.
// - Restore code plus reset rising edge starts restore.
// - Software command in a functional mode also starts a restore.
// - Settings: none, parameters, image and parameters.
// - Factory image sector hidden from host accesses.
// - Restore resumes after power loss until complete.
// - Restore waits about eight seconds.
module bsm_boot_strap_mode_select
    import bsm_pkg::*;
#(
    parameter longint RESTORE_CYCLES = RESTORE_CYC,
    parameter int BREAK_CYCLES = BREAK_CYC,
    parameter logic [31:0] IMAGE_SECTOR = 32'h0000_0000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Board straps and pins
    input wire logic [STRAP_W-1:0] boot_strap_i,
    input wire logic radio_side_reset_pin_i,
    input wire logic uart_rx_i,
    // Software restore control
    input wire logic sw_restore_i,
    input wire bsm_pkg::bsm_restore_type restore_sel_i,
    // Non-volatile restore-pending flag, kept across power loss
    input wire logic nv_pending_i,
    output logic nv_pending_set_o,
    output logic nv_pending_clr_o,
    // Host access to serial flash store
    input wire logic host_req_i,
    input wire logic [31:0] host_sector_i,
    output logic host_grant_o,
    // Status
    output logic [STRAP_W-1:0] strap_latched_o,
    output bsm_pkg::bsm_mode_type mode_o,
    output bsm_pkg::bsm_boot_type boot_o,
    output logic strap_pulldown_en_o,
    output logic restore_busy_o,
    output logic restore_image_o,
    output logic restore_params_o,
    output logic boot_done_o
);
    import bsm_pkg::*;

    // ------------------------------------------------------------------
    // Strap latch
    // ------------------------------------------------------------------
    logic latched_r;
    logic [STRAP_W-1:0] strap_r;
    logic rst_pin_d_r;
    logic brk;
    logic rst_rise;
    logic [63:0] cnt_r;
    bsm_mode_type mode_nxt;

    assign rst_rise = radio_side_reset_pin_i && !rst_pin_d_r;

    // Pulldowns stay on until the sample is taken.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latched_r <= 1'b0;
            strap_r <= RUN_FOUR_WIRE_CODE;
            strap_latched_o <= RUN_FOUR_WIRE_CODE;
            strap_pulldown_en_o <= 1'b1;
        end else if (!latched_r) begin
            latched_r <= 1'b1;
            strap_r <= boot_strap_i;
            strap_latched_o <= boot_strap_i;
            strap_pulldown_en_o <= 1'b0;
        end else if (mode_o == MODE_UART_LOAD &&
                     boot_strap_i != strap_r) begin
            strap_r <= boot_strap_i;
            strap_latched_o <= boot_strap_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // The pin idles high, so no false rising edge follows reset.
            rst_pin_d_r <= 1'b1;
        end else begin
            rst_pin_d_r <= radio_side_reset_pin_i;
        end
    end

    bsm_break_det #(
        .BREAK_CYCLES(BREAK_CYCLES)
    ) u_brk (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(mode_o == MODE_UART_PROBE),
        .uart_rx_i(uart_rx_i),
        .break_o(brk)
    );

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    function automatic bsm_mode_type decode(input logic [STRAP_W-1:0] s);
        case (s)
            LOAD_OVER_SERIAL_CODE: decode = MODE_UART_LOAD;
            RUN_TWO_WIRE_CODE: decode = MODE_FUNC_TWO_WIRE;
            RUN_FOUR_WIRE_CODE: decode = MODE_FUNC_FOUR_WIRE;
            PROBE_LOAD_OR_RUN_CODE: decode = MODE_UART_PROBE;
            RESTORE_DEFAULTS_CODE: decode = MODE_FACTORY_RESTORE;
            default: decode = MODE_FUNC_FOUR_WIRE;
        endcase
    endfunction

    always_comb begin
        mode_nxt = mode_o;
        case (mode_o)
            MODE_NONE: begin
                if (latched_r) begin
                    mode_nxt = nv_pending_i ? MODE_FACTORY_RESTORE
                                            : decode(strap_r);
                end
            end
            MODE_UART_LOAD: begin
                // Only a change of the straps ends the wait for a load.
                if (boot_strap_i != strap_r) begin
                    mode_nxt = decode(boot_strap_i);
                end
            end
            MODE_UART_PROBE: begin
                if (brk) begin
                    mode_nxt = MODE_UART_LOAD;
                end else if (cnt_r >=
                             64'(BREAK_CYCLES) * 64'(PROBE_SPAN)) begin
                    mode_nxt = MODE_FUNC_FOUR_WIRE;
                end
            end
            MODE_FACTORY_RESTORE: begin
                if (restore_busy_o && cnt_r >= 64'(RESTORE_CYCLES)) begin
                    mode_nxt = MODE_FUNC_FOUR_WIRE;
                end
            end
            MODE_FUNC_TWO_WIRE, MODE_FUNC_FOUR_WIRE: begin
                if (sw_restore_i && restore_sel_i != RST_NONE) begin
                    mode_nxt = MODE_FACTORY_RESTORE;
                end
            end
            default: mode_nxt = MODE_NONE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_o <= MODE_NONE;
        end else begin
            mode_o <= mode_nxt;
        end
    end

    // Shared cycle counter, restarted on each mode change.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
        end else if (mode_nxt != mode_o || !restore_busy_o &&
                     mode_o == MODE_FACTORY_RESTORE) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 64'(1);
        end
    end

    // ------------------------------------------------------------------
    // Restore sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            restore_busy_o <= 1'b0;
            restore_image_o <= 1'b0;
            restore_params_o <= 1'b0;
            nv_pending_set_o <= 1'b0;
            nv_pending_clr_o <= 1'b0;
        end else begin
            nv_pending_set_o <= 1'b0;
            nv_pending_clr_o <= 1'b0;
            if (!restore_busy_o) begin
                if (mode_o == MODE_FACTORY_RESTORE && nv_pending_i) begin
                    restore_busy_o <= 1'b1;
                    restore_image_o <= 1'b1;
                    restore_params_o <= 1'b1;
                end else if (mode_o == MODE_FACTORY_RESTORE && rst_rise) begin
                    restore_busy_o <= 1'b1;
                    restore_image_o <= 1'b1;
                    restore_params_o <= 1'b1;
                    nv_pending_set_o <= 1'b1;
                end else if (mode_nxt == MODE_FACTORY_RESTORE &&
                             mode_o != MODE_NONE &&
                             mode_o != MODE_FACTORY_RESTORE) begin
                    restore_busy_o <= 1'b1;
                    restore_image_o <=
                        (restore_sel_i == RST_IMAGE_PARAMS);
                    restore_params_o <= 1'b1;
                    nv_pending_set_o <= 1'b1;
                end
            end else if (mode_nxt != MODE_FACTORY_RESTORE) begin
                restore_busy_o <= 1'b0;
                restore_image_o <= 1'b0;
                restore_params_o <= 1'b0;
                nv_pending_clr_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_o <= '0;
            boot_done_o <= 1'b0;
            host_grant_o <= 1'b0;
        end else begin
            boot_o.uart_load <= (mode_nxt == MODE_UART_LOAD);
            boot_o.functional <= (mode_nxt == MODE_FUNC_TWO_WIRE) ||
                                 (mode_nxt == MODE_FUNC_FOUR_WIRE);
            boot_o.two_wire_dbg <= (mode_nxt == MODE_FUNC_TWO_WIRE);
            boot_o.four_wire_dbg <= (mode_nxt == MODE_FUNC_FOUR_WIRE) ||
                                    (mode_nxt == MODE_UART_LOAD);
            boot_done_o <= boot_o.functional;
            host_grant_o <= host_req_i &&
                            host_sector_i != IMAGE_SECTOR;
        end
    end
endmodule
`default_nettype wire

// ==== bsm_sva.sv ====
// Checker for the boot strap mode selector.
`timescale 1ns/10ps
`default_nettype none
module bsm_sva
    import bsm_pkg::*;
#(
    parameter logic [31:0] IMAGE_SECTOR = 32'h0000_0000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [STRAP_W-1:0] boot_strap_i,
    input wire logic radio_side_reset_pin_i,
    input wire logic sw_restore_i,
    input wire bsm_pkg::bsm_restore_type restore_sel_i,
    input wire logic host_req_i,
    input wire logic [31:0] host_sector_i,
    input wire logic host_grant_o,
    input wire logic [STRAP_W-1:0] strap_latched_o,
    input wire bsm_pkg::bsm_mode_type mode_o,
    input wire bsm_pkg::bsm_boot_type boot_o,
    input wire logic strap_pulldown_en_o,
    input wire logic restore_busy_o,
    input wire logic restore_image_o,
    input wire logic restore_params_o,
    input wire logic nv_pending_i,
    input wire logic nv_pending_clr_o,
    input wire logic boot_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence booted(logic [2:0] c);
        $fell(strap_pulldown_en_o) && strap_latched_o == c && !nv_pending_i;
    endsequence
    sequence idle_func;
        boot_o.functional && !restore_busy_o;
    endsequence
    strap_latch_a: assert property (
        rstn_i && strap_pulldown_en_o |=>
        !strap_pulldown_en_o && strap_latched_o == $past(boot_strap_i))
        else $error("straps not latched on first edge");
    four_wire_a: assert property (booted(RUN_FOUR_WIRE_CODE) |=>
        mode_o == MODE_FUNC_FOUR_WIRE && boot_o == 4'h5)
        else $error("four wire mode not selected");
    serial_load_a: assert property (booted(LOAD_OVER_SERIAL_CODE) |=>
        mode_o == MODE_UART_LOAD && boot_o == 4'h9)
        else $error("serial load mode not selected");
    probe_wait_a: assert property (booted(PROBE_LOAD_OR_RUN_CODE) |=>
        !boot_o.functional [*8])
        else $error("probe left before break window");
    host_grant_a: assert property (host_grant_o == ($past(host_req_i) &&
        $past(host_sector_i) != IMAGE_SECTOR))
        else $error("host grant wrong");
    pin_restore_a: assert property (
        strap_latched_o == RESTORE_DEFAULTS_CODE && !strap_pulldown_en_o &&
        $rose(radio_side_reset_pin_i) && !restore_busy_o |=>
        restore_busy_o && restore_image_o && restore_params_o)
        else $error("reset pin rise did not start restore");
    sw_params_a: assert property (idle_func and sw_restore_i &&
        restore_sel_i == RST_PARAMS |=>
        restore_busy_o && restore_params_o && !restore_image_o)
        else $error("parameter restore not started");
    sw_refuse_a: assert property (idle_func and sw_restore_i &&
        restore_sel_i == RST_NONE |=> !restore_busy_o)
        else $error("restore started with no setting");
    pending_clear_a: assert property ($fell(restore_busy_o) |->
        ##[0:1] nv_pending_clr_o)
        else $error("pending flag not cleared at end");
    boot_done_a: assert property (
        boot_done_o == $past(boot_o.functional))
        else $error("boot done does not follow functional mode");
endmodule
bind bsm_boot_strap_mode_select bsm_sva #(.IMAGE_SECTOR(IMAGE_SECTOR)) chk (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .boot_strap_i(boot_strap_i),
    .radio_side_reset_pin_i(radio_side_reset_pin_i),
    .sw_restore_i(sw_restore_i),
    .restore_sel_i(restore_sel_i),
    .host_req_i(host_req_i),
    .host_sector_i(host_sector_i),
    .host_grant_o(host_grant_o),
    .strap_latched_o(strap_latched_o),
    .mode_o(mode_o),
    .boot_o(boot_o),
    .strap_pulldown_en_o(strap_pulldown_en_o),
    .restore_busy_o(restore_busy_o),
    .restore_image_o(restore_image_o),
    .restore_params_o(restore_params_o),
    .nv_pending_i(nv_pending_i),
    .nv_pending_clr_o(nv_pending_clr_o),
    .boot_done_o(boot_done_o)
);
`default_nettype wire

// ==== bsm_board.sv ====
// Board model: strap resistors, reset pin driver and serial line.
`timescale 1ns/10ps
`default_nettype none
module bsm_board (
    input wire logic clk_i,
    input wire logic [2:0] code_i,
    input wire logic open_i,
    input wire logic pulldown_en_i,
    input wire logic pin_i,
    input wire logic brk_i,
    output logic [2:0] boot_strap_o,
    output logic radio_side_reset_pin_o,
    output logic uart_rx_o
);
    logic [2:0] drift_r = 3'h5;
    always @(posedge clk_i) begin
        drift_r <= ~drift_r;
    end
    // Open straps float once the pulldowns are released.
    // Straps are changed between boots and also in load mode, while they are sampled.
    assign boot_strap_o = !open_i ? code_i :
                          pulldown_en_i ? 3'h0 : drift_r;
    assign radio_side_reset_pin_o = pin_i;
    assign uart_rx_o = !brk_i;
endmodule
`default_nettype wire

// ==== boot_strap_mode_select_test.sv ====
// Self-checking bench for the boot strap mode selector.
`timescale 1ns/10ps
`default_nettype none
module boot_strap_mode_select_test;
    import bsm_pkg::*;
    typedef struct packed {
        logic [2:0] s;
        bsm_mode_type m;
        bsm_boot_type b;
    } bsm_exp_type;
    localparam logic [31:0] IMG = 32'h0000_0000;
    logic clk_i = 1'b0, rstn_i = 1'b0, open_s = 1'b0, pin = 1'b0, brk = 1'b0;
    logic [2:0] code = 3'h0, boot_strap_i, strap_latched_o;
    logic radio_side_reset_pin_i, uart_rx_i, host_grant_o, boot_done_o;
    logic sw_restore_i = 1'b0, nv_pending_i = 1'b0, host_req_i = 1'b0;
    bsm_restore_type restore_sel_i = RST_NONE;
    logic [31:0] host_sector_i = 32'h0, seed = 32'h0000_73EC;
    bsm_mode_type mode_o, last_mode;
    bsm_boot_type boot_o;
    logic nv_pending_set_o, nv_pending_clr_o, strap_pulldown_en_o;
    logic restore_busy_o, restore_image_o, restore_params_o;
    int mismatches = 0, num_checks = 0, n;
    bsm_exp_type notes[$];
    bsm_exp_type tbl[4] = '{{RUN_TWO_WIRE_CODE, MODE_FUNC_TWO_WIRE, 4'h6},
        {LOAD_OVER_SERIAL_CODE, MODE_UART_LOAD, 4'h9},
        {RUN_FOUR_WIRE_CODE, MODE_FUNC_FOUR_WIRE, 4'h5},
        {PROBE_LOAD_OR_RUN_CODE, MODE_FUNC_FOUR_WIRE, 4'h5}};
    bsm_boot_strap_mode_select #(.RESTORE_CYCLES(100), .BREAK_CYCLES(8),
        .IMAGE_SECTOR(IMG)) uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .boot_strap_i(boot_strap_i),
        .radio_side_reset_pin_i(radio_side_reset_pin_i),
        .uart_rx_i(uart_rx_i), .sw_restore_i(sw_restore_i),
        .restore_sel_i(restore_sel_i), .nv_pending_i(nv_pending_i),
        .nv_pending_set_o(nv_pending_set_o),
        .nv_pending_clr_o(nv_pending_clr_o), .host_req_i(host_req_i),
        .host_sector_i(host_sector_i), .host_grant_o(host_grant_o),
        .strap_latched_o(strap_latched_o), .mode_o(mode_o),
        .boot_o(boot_o), .strap_pulldown_en_o(strap_pulldown_en_o),
        .restore_busy_o(restore_busy_o), .restore_image_o(restore_image_o),
        .restore_params_o(restore_params_o), .boot_done_o(boot_done_o));
    bsm_board board (.clk_i(clk_i), .code_i(code), .open_i(open_s),
        .pulldown_en_i(strap_pulldown_en_o), .pin_i(pin), .brk_i(brk),
        .boot_strap_o(boot_strap_i),
        .radio_side_reset_pin_o(radio_side_reset_pin_i),
        .uart_rx_o(uart_rx_i));
    initial forever #4 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic boot(input logic [2:0] c, input logic o, input logic nv,
        input bsm_exp_type ex);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        code <= c;
        open_s <= o;
        nv_pending_i <= nv;
        notes.push_back(ex);
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (restore_busy_o !== lvl && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // The pending flag is kept outside the device, across power loss.
    always @(posedge clk_i) begin
        if (nv_pending_clr_o) begin
            nv_pending_i <= 1'b0;
        end else if (nv_pending_set_o) begin
            nv_pending_i <= 1'b1;
        end
    end
    always @(negedge clk_i) begin
        if (mode_o !== last_mode && notes.size() > 0 && mode_o inside
            {MODE_UART_LOAD, MODE_FUNC_TWO_WIRE, MODE_FUNC_FOUR_WIRE}) begin
            check({strap_latched_o, mode_o, boot_o}, notes.pop_front());
        end
        last_mode = mode_o;
    end
    initial begin
        repeat (6000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
    initial begin
        boot(3'h0, 1'b1, 1'b0, {3'h0, MODE_FUNC_FOUR_WIRE, 4'h5});
        repeat (30) @(posedge clk_i);
        foreach (tbl[i]) begin
            boot(tbl[i].s, 1'b0, 1'b0, tbl[i]);
            repeat (30) @(posedge clk_i);
        end
        brk <= 1'b1;
        boot(PROBE_LOAD_OR_RUN_CODE, 1'b0, 1'b0,
            {PROBE_LOAD_OR_RUN_CODE, MODE_UART_LOAD, 4'h9});
        repeat (30) @(posedge clk_i);
        code <= RUN_TWO_WIRE_CODE;
        notes.push_back({RUN_TWO_WIRE_CODE, MODE_FUNC_TWO_WIRE, 4'h6});
        repeat (30) @(posedge clk_i);
        brk <= 1'b0;
        boot(RESTORE_DEFAULTS_CODE, 1'b0, 1'b0,
            {RESTORE_DEFAULTS_CODE, MODE_FUNC_FOUR_WIRE, 4'h5});
        repeat (20) @(negedge clk_i);
        check(restore_busy_o, 1'b0);
        @(posedge clk_i);
        pin <= 1'b1;
        wait_busy(1'b1, 4);
        check({restore_busy_o, restore_image_o, restore_params_o}, 3'h7);
        @(negedge clk_i);
        check(nv_pending_i, 1'b1);
        wait_busy(1'b0, 300);
        check(n >= 99 && n <= 101, 1'b1);
        @(posedge clk_i);
        pin <= 1'b0;
        boot(RUN_FOUR_WIRE_CODE, 1'b0, 1'b1,
            {RUN_FOUR_WIRE_CODE, MODE_FUNC_FOUR_WIRE, 4'h5});
        wait_busy(1'b1, 8);
        check({restore_busy_o, restore_image_o, restore_params_o}, 3'h7);
        wait_busy(1'b0, 300);
        repeat (4) @(negedge clk_i);
        check(nv_pending_i, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            restore_sel_i <= bsm_restore_type'(i);
            sw_restore_i <= 1'b1;
            @(posedge clk_i);
            sw_restore_i <= 1'b0;
            wait_busy(1'b1, 4);
            check({restore_busy_o, restore_image_o, restore_params_o},
                {i != 0, i == 2, i != 0});
            wait_busy(1'b0, 300);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            host_req_i <= 1'b1;
            host_sector_i <= (i == 0) ? IMG : rnd() | 32'h1;
            @(posedge clk_i);
            @(negedge clk_i);
            check(host_grant_o, host_sector_i != IMG);
        end
        @(posedge clk_i);
        host_req_i <= 1'b0;
        check(notes.size(), 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
